// >>> design/rcsv_rail_ctrl.sv
// What this block does
// (R1) Command BB loads level setup fields
// (R2) Commands BC/BD set rail level codes
// (R3) Reference updates one fixed delay after packet
// (R4) Packets accepted with or without PEC
// (R5) Host keeps under four codes per millisecond
// (R6) Host sends codes only on change
// (R7) Test port disabled after reset by default
// (R8) Boot-loader entry command enables test port
// (R9) Blank configuration at startup enables test port
// (R10) Invalid strap address at startup enables test port
// (R11) Test port takes both phase-align pins
// (R12) Supply good starts startup then operation
// (R13) Low external reset pin holds reset
// (R14) Five switch methods per rail
// (R15) Switch setting gives control pin polarity
// (R16) Rail enable pins share that polarity
// (R17) Pin method ANDs control and enable
// (R18) Per-rail good plus AND of all
// (R19) Good indicators are open-drain outputs
// (R20) Eight-bit mode takes serial codes only
// (R21) Reference is code times slope plus low
// (R22) Good indicator low while rail off
module rcsv_rail_ctrl #(
  parameter int DAC_DELAY = rcsv_pkg::DAC_DELAY_CYC,
  parameter int STARTUP = rcsv_pkg::STARTUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic digital_supply_rail,
  input wire logic external_reset_low_pin,
  input wire logic [6:0] addr_pins,
  input wire logic flash_blank,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic bus_ctrl_pin,
  input wire logic [1:0] rail_enable_pins,
  input wire logic [1:0] rail_ok,
  output logic [1:0] rail_good_outputs,
  output logic [1:0] rail_good_oe,
  output logic all_rails_good_output,
  output logic all_rails_good_oe,
  input wire logic phase_align_input,
  input wire logic phase_ref,
  output logic phase_align_output,
  output logic phase_align_oe,
  output logic phase_align_seen,
  output logic test_port_en,
  output logic [1:0] rail_on,
  output logic [15:0] vref_dac1,
  output logic [15:0] vref_dac2,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata
);

  localparam int DW = $clog2(DAC_DELAY + 1);
  localparam int SW = $clog2(STARTUP + 1);

  // ********
  // Functions
  // ********

  // Packet check byte, polynomial x8+x2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction

  // Payload length for a command, with a known flag on top
  function automatic logic [4:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      rcsv_pkg::CMD_LEVEL_SETUP: return {1'b1, rcsv_pkg::LEN_SETUP};
      rcsv_pkg::CMD_RAIL1_LEVEL: return {1'b1, rcsv_pkg::LEN_LEVEL};
      rcsv_pkg::CMD_RAIL2_LEVEL: return {1'b1, rcsv_pkg::LEN_LEVEL};
      rcsv_pkg::CMD_BOOT_ENTRY: return {1'b1, rcsv_pkg::LEN_BOOT};
      default: return 5'h00;
    endcase
  endfunction

  // Reference = low + code * (high - low) / (2^width - 1)
  function automatic logic [15:0] calc_vref(input logic [7:0] code,
                                            input logic [1:0] mode,
                                            input logic [15:0] hi,
                                            input logic [15:0] lo);
    logic [15:0] span;
    logic [23:0] prod;
    logic [23:0] quo;
    span = (hi > lo) ? hi - lo : 16'h0000;
    quo = 24'h000000;
    case (mode)
      rcsv_pkg::MODE_4BIT:
      begin
        prod = {12'h000, code[3:0]} * {8'h00, span};
        quo = prod / 24'h00000F;
      end
      rcsv_pkg::MODE_6BIT:
      begin
        prod = {10'h000, code[5:0]} * {8'h00, span};
        quo = prod / 24'h00003F;
      end
      default:
      begin
        prod = {8'h00, code} * {8'h00, span};
        quo = prod / 24'h0000FF;
      end
    endcase
    return lo + quo[15:0];
  endfunction

  // Pin level seen through the configured polarity
  function automatic logic pin_active(input logic lvl, input logic pol);
    return pol ? lvl : ~lvl;
  endfunction

  // ********
  // Pin synchronisers
  // ********
  logic [15:0] sync1_ff, sync2_ff;
  logic supply_s, external_reset_low_pin_s, ctrl_s, blank_s, phase_s;
  logic [1:0] en_s, ok_s;
  logic [6:0] addr_s;

  // Two flops on every asynchronous pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end
    else
    begin
      sync1_ff <= {digital_supply_rail, external_reset_low_pin,
                   bus_ctrl_pin, rail_enable_pins, rail_ok, flash_blank,
                   phase_align_input, addr_pins};
      sync2_ff <= sync1_ff;
    end
  end

  assign supply_s = sync2_ff[15];
  assign external_reset_low_pin_s = sync2_ff[14];
  assign ctrl_s = sync2_ff[13];
  assign en_s = sync2_ff[12:11];
  assign ok_s = sync2_ff[10:9];
  assign blank_s = sync2_ff[8];
  assign phase_s = sync2_ff[7];
  assign addr_s = sync2_ff[6:0];

  // ********
  // Reset entry and startup sequence
  // ********
  rcsv_pkg::rcsv_state_t state_ff;
  logic [SW-1:0] boot_cnt_ff;
  logic hold, boot_done, running;
  logic [6:0] dev_addr_ff;

  assign hold = ~supply_s | ~external_reset_low_pin_s; // R12 R13
  assign boot_done = (state_ff == rcsv_pkg::ST_BOOT) &&
                     (boot_cnt_ff == SW'(STARTUP - 1));
  assign running = (state_ff == rcsv_pkg::ST_RUN);

  // Hold, run startup, then operate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= rcsv_pkg::ST_HOLD;
      boot_cnt_ff <= '0;
    end
    else if (hold)
    begin
      state_ff <= rcsv_pkg::ST_HOLD; // R13
      boot_cnt_ff <= '0;
    end
    else
    begin
      case (state_ff)
        rcsv_pkg::ST_HOLD: state_ff <= rcsv_pkg::ST_BOOT; // R12
        rcsv_pkg::ST_BOOT:
        begin
          boot_cnt_ff <= boot_cnt_ff + SW'(1);
          if (boot_done)
            state_ff <= rcsv_pkg::ST_RUN; // R12
        end
        rcsv_pkg::ST_RUN: state_ff <= rcsv_pkg::ST_RUN;
        default: state_ff <= rcsv_pkg::ST_HOLD;
      endcase
    end
  end

  // Bus address strapped at the end of startup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dev_addr_ff <= rcsv_pkg::ADDR_INVALID;
    else if (boot_done)
      dev_addr_ff <= addr_s;
  end

  // ********
  // Serial command reception
  // ********
  logic rx_start, rx_stop, rx_vld;
  logic [7:0] rx_byte;
  logic rx_en;

  assign rx_en = running && (dev_addr_ff != rcsv_pkg::ADDR_INVALID);
  assign sda_out = 1'b0;

  rcsv_pmbus_rx u_rx (
    .clk(clk),
    .rst(rst),
    .en(rx_en),
    .dev_addr(dev_addr_ff),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .start_ok(rx_start),
    .stop_seen(rx_stop),
    .byte_vld(rx_vld),
    .byte_data(rx_byte)
  );

  logic [7:0] buf_ff [0:7];
  logic [3:0] cnt_ff;
  logic [7:0] crc_ff;
  logic frame_ff;
  logic [4:0] len_k;
  logic frame_ok;

  // Collect bytes and running check value of one write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      crc_ff <= 8'h00;
      frame_ff <= 1'b0;
      for (int i = 0; i < 8; i++)
        buf_ff[i] <= 8'h00;
    end
    else if (rx_start)
    begin
      frame_ff <= 1'b1;
      cnt_ff <= 4'h0;
      crc_ff <= crc8(8'h00, {dev_addr_ff, 1'b0});
    end
    else if (rx_stop || !rx_en)
      frame_ff <= 1'b0;
    else if (rx_vld && frame_ff)
    begin
      crc_ff <= crc8(crc_ff, rx_byte);
      if (cnt_ff < 4'h8)
        buf_ff[cnt_ff[2:0]] <= rx_byte;
      if (cnt_ff < rcsv_pkg::FRAME_MAX)
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Exact length, or one more byte whose check comes out zero
  assign len_k = cmd_len(buf_ff[0]);
  assign frame_ok = rx_stop && frame_ff && len_k[4] &&
                    ((cnt_ff == len_k[3:0] + 4'h1) ||
                     (cnt_ff == len_k[3:0] + 4'h2 && crc_ff == 8'h00)); // R4

  // ********
  // Level setup and level codes
  // ********
  logic [1:0] mode_ff;
  logic [15:0] high_ff, low_ff;
  logic [7:0] init_code_ff;
  logic [7:0] code1_ff, code2_ff;
  logic [1:0] new_code;

  // Setup fields: mode, high limit, low limit, power-up code
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= rcsv_pkg::MODE_RST;
      high_ff <= rcsv_pkg::HIGH_RST;
      low_ff <= rcsv_pkg::LOW_RST;
      init_code_ff <= rcsv_pkg::INIT_CODE_RST;
    end
    else if (frame_ok && buf_ff[0] == rcsv_pkg::CMD_LEVEL_SETUP) // R1
    begin
      mode_ff <= buf_ff[1][1:0];
      high_ff <= {buf_ff[3], buf_ff[2]};
      low_ff <= {buf_ff[5], buf_ff[4]};
      init_code_ff <= buf_ff[6];
    end
  end

  // Serial codes only count in eight-bit mode
  assign new_code[0] = frame_ok && mode_ff == rcsv_pkg::MODE_8BIT &&
                       buf_ff[0] == rcsv_pkg::CMD_RAIL1_LEVEL; // R2 R20
  assign new_code[1] = frame_ok && mode_ff == rcsv_pkg::MODE_8BIT &&
                       buf_ff[0] == rcsv_pkg::CMD_RAIL2_LEVEL; // R2 R20

  // Codes start from the power-up code after startup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code1_ff <= rcsv_pkg::INIT_CODE_RST;
      code2_ff <= rcsv_pkg::INIT_CODE_RST;
    end
    else if (boot_done)
    begin
      code1_ff <= init_code_ff; // R1
      code2_ff <= init_code_ff;
    end
    else
    begin
      if (new_code[0])
        code1_ff <= buf_ff[1];
      if (new_code[1])
        code2_ff <= buf_ff[1];
    end
  end

  // ********
  // Delayed reference update
  // ********
  logic [1:0] pend_ff;
  logic busy_ff, cur_ff;
  logic [DW-1:0] dly_ff;
  logic pick, dly_done;

  assign pick = !busy_ff && (pend_ff != 2'b00) && running;
  assign dly_done = busy_ff && (dly_ff == DW'(DAC_DELAY - 1));

  // One update at a time, rail 1 served first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_ff <= 2'b00;
      busy_ff <= 1'b0;
      cur_ff <= 1'b0;
      dly_ff <= '0;
    end
    else if (!running && !boot_done)
    begin
      pend_ff <= 2'b00;
      busy_ff <= 1'b0;
      dly_ff <= '0;
    end
    else
    begin
      for (int r = 0; r < 2; r++)
      begin
        if (boot_done || new_code[r])
          pend_ff[r] <= 1'b1; // Set wins over pick
        else if (pick && r[0] == ~pend_ff[0])
          pend_ff[r] <= 1'b0; // Clear the rail being picked
      end
      if (pick)
      begin
        busy_ff <= 1'b1;
        cur_ff <= ~pend_ff[0];
        dly_ff <= '0;
      end
      else if (dly_done)
        busy_ff <= 1'b0; // R3
      else if (busy_ff)
        dly_ff <= dly_ff + DW'(1); // R3
    end
  end

  // Reference DAC words
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vref_dac1 <= 16'h0000;
      vref_dac2 <= 16'h0000;
    end
    else if (dly_done && !cur_ff)
      vref_dac1 <= calc_vref(code1_ff, mode_ff, high_ff, low_ff); // R21
    else if (dly_done && cur_ff)
      vref_dac2 <= calc_vref(code2_ff, mode_ff, high_ff, low_ff); // R21
  end

  // ********
  // Test-access port and phase-align pins
  // ********

  // Off by default; set by boot entry, blank flash or bad strap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      test_port_en <= 1'b0; // R7
    else if (state_ff == rcsv_pkg::ST_HOLD)
      test_port_en <= 1'b0; // R7
    else if (boot_done && (blank_s || addr_s == rcsv_pkg::ADDR_INVALID))
      test_port_en <= 1'b1; // R9 R10
    else if (frame_ok && buf_ff[0] == rcsv_pkg::CMD_BOOT_ENTRY)
      test_port_en <= 1'b1; // R8
  end

  // Shared pins belong to the test port while it is on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_align_output <= 1'b0;
      phase_align_oe <= 1'b0;
      phase_align_seen <= 1'b0;
    end
    else
    begin
      phase_align_output <= phase_ref;
      phase_align_oe <= running & ~test_port_en; // R11
      phase_align_seen <= phase_s & ~test_port_en; // R11
    end
  end

  // ********
  // Rail on/off and good indicators
  // ********
  logic [1:0] ctrl_ff;
  logic [7:0] onoff_ff;
  logic [1:0] on_k;
  logic [1:0] good_ff;

  // Resolve the on condition per rail
  always_comb
  begin
    logic pol;
    logic [2:0] meth;
    logic pin_on;
    meth = 3'h0;
    pin_on = 1'b0;
    pol = onoff_ff[rcsv_pkg::ONOFF_POL]; // R15
    on_k = 2'b00;
    for (int r = 0; r < 2; r++)
    begin
      meth = r == 0 ? onoff_ff[rcsv_pkg::ONOFF_M1_LSB +: 3]
                    : onoff_ff[rcsv_pkg::ONOFF_M2_LSB +: 3];
      pin_on = pin_active(ctrl_s, pol) & pin_active(en_s[r], pol); // R16 R17
      case (meth) // R14
        rcsv_pkg::METH_OFF: on_k[r] = 1'b0;
        rcsv_pkg::METH_AUTO: on_k[r] = 1'b1;
        rcsv_pkg::METH_PIN: on_k[r] = pin_on;
        rcsv_pkg::METH_OP: on_k[r] = ctrl_ff[r];
        rcsv_pkg::METH_PIN_AND_OP: on_k[r] = pin_on & ctrl_ff[r];
        default: on_k[r] = 1'b0;
      endcase
    end
  end

  // Rail state and open-drain good outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rail_on <= 2'b00;
      good_ff <= 2'b00;
    end
    else
    begin
      rail_on <= running ? on_k : 2'b00;
      good_ff <= running ? (on_k & rail_on & ok_s) : 2'b00; // R22
    end
  end

  assign rail_good_outputs = 2'b00; // R19
  assign rail_good_oe = ~good_ff; // R18 R19
  assign all_rails_good_output = 1'b0; // R19
  assign all_rails_good_oe = ~(&good_ff); // R18

  // ********
  // Register port
  // ********

  // Software writes: operation bits and switch setting
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_ff <= rcsv_pkg::CTRL_RST;
      onoff_ff <= rcsv_pkg::ONOFF_RST;
    end
    else if (reg_we && reg_addr == rcsv_pkg::REG_CTRL)
      ctrl_ff <= reg_wdata[1:0];
    else if (reg_we && reg_addr == rcsv_pkg::REG_ONOFF)
      onoff_ff <= reg_wdata[7:0];
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (!reg_re)
      reg_rdata <= 16'h0000;
    else
    begin
      case (reg_addr)
        rcsv_pkg::REG_CTRL: reg_rdata <= {14'h0000, ctrl_ff};
        rcsv_pkg::REG_ONOFF: reg_rdata <= {8'h00, onoff_ff};
        rcsv_pkg::REG_STATUS:
          reg_rdata <= {5'h00, pend_ff, &good_ff, good_ff, rail_on,
                        test_port_en, state_ff};
        rcsv_pkg::REG_VREF1: reg_rdata <= vref_dac1;
        rcsv_pkg::REG_VREF2: reg_rdata <= vref_dac2;
        rcsv_pkg::REG_MODE: reg_rdata <= {init_code_ff, 6'h00, mode_ff};
        rcsv_pkg::REG_HIGH: reg_rdata <= high_ff;
        rcsv_pkg::REG_LOW: reg_rdata <= low_ff;
        rcsv_pkg::REG_CODES: reg_rdata <= {code2_ff, code1_ff};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// >>> common/rcsv_pkg.sv
package rcsv_pkg;

  // ****************************************************************
  // Command codes and payload lengths
  // ****************************************************************
  localparam logic [7:0] CMD_LEVEL_SETUP = 8'hBB;
  localparam logic [7:0] CMD_RAIL1_LEVEL = 8'hBC;
  localparam logic [7:0] CMD_RAIL2_LEVEL = 8'hBD;
  localparam logic [7:0] CMD_BOOT_ENTRY = 8'hD9;
  localparam logic [3:0] LEN_SETUP = 4'h6;
  localparam logic [3:0] LEN_LEVEL = 4'h1;
  localparam logic [3:0] LEN_BOOT = 4'h0;
  localparam logic [3:0] FRAME_MAX = 4'h9;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ONOFF = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_VREF1 = 8'h0C;
  localparam logic [7:0] REG_VREF2 = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [7:0] REG_HIGH = 8'h18;
  localparam logic [7:0] REG_LOW = 8'h1C;
  localparam logic [7:0] REG_CODES = 8'h20;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int ONOFF_M1_LSB = 0;
  localparam int ONOFF_M2_LSB = 4;
  localparam int ONOFF_POL = 7;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] ONOFF_RST = 8'h91;
  localparam logic [1:0] MODE_RST = 2'h2;
  localparam logic [15:0] HIGH_RST = 16'h0400;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [7:0] INIT_CODE_RST = 8'h00;
  localparam logic [6:0] ADDR_INVALID = 7'h7E;

  // ****************************************************************
  // Switch methods and level-code formats
  // ****************************************************************
  localparam logic [2:0] METH_OFF = 3'h0;
  localparam logic [2:0] METH_AUTO = 3'h1;
  localparam logic [2:0] METH_PIN = 3'h2;
  localparam logic [2:0] METH_OP = 3'h3;
  localparam logic [2:0] METH_PIN_AND_OP = 3'h4;
  localparam logic [1:0] MODE_4BIT = 2'h0;
  localparam logic [1:0] MODE_6BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int DAC_DELAY_NS = 140000;
  localparam int DAC_DELAY_CYC = (DAC_DELAY_NS * CLK_MHZ) / 1000;
  localparam int STARTUP_CYC = 256;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_BOOT = 3'b010,
    ST_RUN = 3'b100
  } rcsv_state_t;

endpackage

// >>> design/rcsv_pmbus_rx.sv
module rcsv_pmbus_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [6:0] dev_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic start_ok,
  output logic stop_seen,
  output logic byte_vld,
  output logic [7:0] byte_data
);

  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic act_ff, addr_phase_ff, ack_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic scl_rise, scl_fall, cond_start, cond_stop;

  // Two-stage synchronisers plus one history stage for edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  // Bus edges and start/stop conditions
  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign cond_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign cond_stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  assign sda_oe = ack_ff;

  // Byte shifter, address match and acknowledge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      act_ff <= 1'b0;
      addr_phase_ff <= 1'b0;
      ack_ff <= 1'b0;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      start_ok <= 1'b0;
      stop_seen <= 1'b0;
      byte_vld <= 1'b0;
      byte_data <= 8'h00;
    end
    else
    begin
      start_ok <= 1'b0;
      byte_vld <= 1'b0;
      stop_seen <= en & cond_stop;
      if (!en)
      begin
        act_ff <= 1'b0;
        ack_ff <= 1'b0;
        bitcnt_ff <= 4'h0;
      end
      else if (cond_start)
      begin
        act_ff <= 1'b1;
        addr_phase_ff <= 1'b1;
        ack_ff <= 1'b0;
        bitcnt_ff <= 4'h0;
      end
      else if (cond_stop)
      begin
        act_ff <= 1'b0;
        ack_ff <= 1'b0;
      end
      else if (act_ff)
      begin
        if (scl_rise && bitcnt_ff < 4'h8)
        begin
          shift_ff <= {shift_ff[6:0], sda_s2_ff};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        else if (scl_fall && bitcnt_ff == 4'h8)
        begin
          bitcnt_ff <= 4'h9;
          if (!addr_phase_ff)
          begin
            ack_ff <= 1'b1;
            byte_vld <= 1'b1;
            byte_data <= shift_ff;
          end
          else if (shift_ff[7:1] == dev_addr && !shift_ff[0])
          begin
            ack_ff <= 1'b1;
            addr_phase_ff <= 1'b0;
            start_ok <= 1'b1;
          end
          else
            act_ff <= 1'b0; // Other target or a read: stay silent
        end
        else if (scl_fall && bitcnt_ff == 4'h9)
        begin
          ack_ff <= 1'b0;
          bitcnt_ff <= 4'h0;
        end
      end
    end
  end

endmodule

// >>> test/rcsv_rail_ctrl_properties.sv
module rcsv_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic digital_supply_rail,
  input wire logic external_reset_low_pin,
  input wire logic sda_out,
  input wire logic [1:0] rail_ok,
  input wire logic [1:0] rail_good_outputs,
  input wire logic [1:0] rail_good_oe,
  input wire logic all_rails_good_output,
  input wire logic all_rails_good_oe,
  input wire logic phase_align_oe,
  input wire logic phase_align_seen,
  input wire logic test_port_en,
  input wire logic [1:0] rail_on
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Indicator and hold properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_od;
    rail_good_outputs == 2'h0 && !all_rails_good_output && !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_all;
    all_rails_good_oe == (rail_good_oe != 2'h0);
  endproperty
  a_all: assert property (p_all) else $error("combined good");
  property p_off0;
    !rail_on[0] |=> rail_good_oe[0];
  endproperty
  a_off0: assert property (p_off0) else $error("rail1 good off");
  property p_off1;
    !rail_on[1] |=> rail_good_oe[1];
  endproperty
  a_off1: assert property (p_off1) else $error("rail2 good off");
  property p_tp;
    test_port_en [*2] |-> !phase_align_oe && !phase_align_seen;
  endproperty
  a_tp: assert property (p_tp) else $error("phase pins used");
  property p_pin;
    !external_reset_low_pin [*6] |-> rail_on == 2'h0 && !test_port_en;
  endproperty
  a_pin: assert property (p_pin) else $error("pin hold");
  property p_sup;
    !digital_supply_rail [*6] |-> rail_on == 2'h0 && !test_port_en;
  endproperty
  a_sup: assert property (p_sup) else $error("supply hold");
  property p_ok;
    !rail_ok[0] [*5] |-> rail_good_oe[0];
  endproperty
  a_ok: assert property (p_ok) else $error("rail1 status");
  c_tp: cover property ($rose(test_port_en));
  c_good: cover property (!all_rails_good_oe);
  c_off: cover property (rail_on == 2'h0);
endmodule

bind rcsv_rail_ctrl rcsv_chk u_rcsv_chk (
  .clk, .rst, .digital_supply_rail, .external_reset_low_pin, .sda_out,
  .rail_ok, .rail_good_outputs, .rail_good_oe, .all_rails_good_output,
  .all_rails_good_oe, .phase_align_oe, .phase_align_seen, .test_port_en,
  .rail_on
);

// >>> test/rcsv_host.sv
module rcsv_host (
  output logic scl = 1'b1,
  output logic sda_h = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // Checksum step, polynomial 07h
  function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  // One bit at 125 ns; data moves only while the clock is low
  task automatic bit_tx(logic b);
    scl = 1'b0;
    #31 sda_h = b;
    #31 scl = 1'b1;
    #63;
  endtask
  // Write frame; pec 1 appends checksum, 2 a corrupted one
  task automatic frame(logic [7:0] q[$], logic [1:0] pec);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) c = crc(c, q[i]);
    if (pec != 2'h0) q.push_back(c ^ {7'h0, pec[1]});
    sda_h = 1'b0;
    #62;
    foreach (q[i])
    begin
      for (int k = 7; k >= 0; k--) bit_tx(q[i][k]);
      bit_tx(1'b1);
    end
    scl = 1'b0;
    #31 sda_h = 1'b0;
    #31 scl = 1'b1;
    #31 sda_h = 1'b1;
    #63;
  endtask
endmodule

// >>> test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, flash_blank = 1'b0, bus_ctrl_pin = 1'b0;
  logic digital_supply_rail = 1'b1, external_reset_low_pin = 1'b1;
  logic reg_we = 1'b0, reg_re = 1'b0, re_d = 1'b0;
  logic phase_align_input = 1'b0, phase_ref = 1'b0;
  logic scl_in, sda_in, sda_h, sda_oe, test_port_en;
  logic [6:0] addr_pins = 7'h12;
  logic [1:0] rail_enable_pins = 2'h0, rail_ok = 2'h3, rail_on;
  logic [7:0] reg_addr = 8'h00, c1, c2;
  logic [4:0] r;
  logic [15:0] reg_wdata = 16'h0000, l1 = 16'h0000, l2 = 16'h0000;
  logic [15:0] reg_rdata, vref_dac1, vref_dac2, qr[$], q1[$], q2[$];
  logic act, e;
  int errors = 0, compares = 0;
  rcsv_rail_ctrl #(.DAC_DELAY(20), .STARTUP(8)) u_rcsv_rail_ctrl (
    .clk, .rst, .digital_supply_rail, .external_reset_low_pin, .addr_pins,
    .flash_blank, .scl_in, .sda_in, .sda_out(), .sda_oe, .bus_ctrl_pin,
    .rail_enable_pins, .rail_ok, .rail_good_outputs(), .rail_good_oe(),
    .all_rails_good_output(), .all_rails_good_oe(), .phase_align_input,
    .phase_ref, .phase_align_output(), .phase_align_oe(),
    .phase_align_seen(), .test_port_en, .rail_on, .vref_dac1, .vref_dac2,
    .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  rcsv_host u_rcsv_host (.scl(scl_in), .sda_h);
  assign sda_in = sda_h & ~sda_oe;
  always #4 clk = ~clk;
  task automatic chk(string n, logic [15:0] x, logic [15:0] g);
    compares++;
    if (x !== g)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= w;
    reg_re <= !w;
    if (!w) qr.push_back(d);
    @(posedge clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
  endtask
  // Retire oldest note when read data or a reference word appears
  always @(posedge clk)
  begin
    re_d <= reg_re;
    if (re_d) chk("rdata", qr.pop_front(), reg_rdata);
    if (!rst && vref_dac1 !== l1) chk("vref1", q1.pop_front(), vref_dac1);
    if (!rst && vref_dac2 !== l2) chk("vref2", q2.pop_front(), vref_dac2);
    l1 <= vref_dac1;
    l2 <= vref_dac2;
    {phase_ref, phase_align_input} <= 2'($urandom);
  end
  initial
  begin
    void'($urandom(32'h87A62E93));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    chk("on", 16'h3, {14'h0, rail_on});
    acc(0, 8'h04, 16'h0091);
    acc(0, 8'h30, 16'h0000);
    u_rcsv_host.frame('{8'h24, 8'hBB, 2, 8'hFF, 0, 0, 0, 0}, 1);
    acc(0, 8'h14, 16'h0002);
    c1 = {1'b1, 7'($urandom)};
    c2 = c1 ^ 8'h5A;
    q1.push_back({8'h00, c1});
    u_rcsv_host.frame('{8'h24, 8'hBC, c1}, 1);
    repeat (30) @(posedge clk);
    q2.push_back({8'h00, c2});
    u_rcsv_host.frame('{8'h24, 8'hBD, c2}, 0);
    repeat (30) @(posedge clk);
    u_rcsv_host.frame('{8'h24, 8'hBC, ~c1}, 2);
    repeat (30) @(posedge clk);
    chk("pend", 16'h0, 16'(q1.size() + q2.size()));
    acc(0, 8'h20, {c2, c1});
    for (int i = 0; i < 15; i++)
    begin
      r = 5'($urandom);
      acc(1, 8'h00, {15'h0, r[4]});
      acc(1, 8'h04, {8'h0, r[0], 3'h1, 1'b0, 3'(i % 5)});
      bus_ctrl_pin <= r[1];
      rail_enable_pins <= r[3:2];
      rail_ok <= 2'($urandom);
      repeat (8) @(posedge clk);
      act = r[1] == r[0] && r[2] == r[0];
      e = i % 5 == 1 || i % 5 == 2 && act || i % 5 == 3 && r[4];
      e = e || i % 5 == 4 && act && r[4];
      chk("on1", {15'h0, e}, {15'h0, rail_on[0]});
    end
    u_rcsv_host.frame('{8'h24, 8'hD9}, 0);
    repeat (10) @(posedge clk);
    chk("tport", 16'h1, {15'h0, test_port_en});
    q1.push_back(16'h0000);
    q2.push_back(16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      digital_supply_rail <= i != 1;
      external_reset_low_pin <= i == 1;
      addr_pins <= i == 0 ? 7'h7E : 7'h12;
      flash_blank <= i == 1;
      repeat (8) @(posedge clk);
      digital_supply_rail <= 1'b1;
      external_reset_low_pin <= 1'b1;
      repeat (60) @(posedge clk);
      chk("tport", {15'h0, i < 2}, {15'h0, test_port_en});
    end
    chk("pend", 16'h0, 16'(q1.size() + q2.size()));
    finish_test();
  end
endmodule
